// ---- hw/hswc_pkg.sv ----
package hswc_pkg;

   // Interface widths and counts
   localparam int PORT_COUNT      = 3;
   localparam int PORT_WIDTH      = 4;
   localparam int KEY_WIDTH       = 4;
   localparam int LCD_SEG_WIDTH   = 32;
   localparam int LCD_COM_WIDTH   = 4;
   localparam int REQ_WIDTH       = 8;

   // Port index inside three-bit port vectors
   localparam int PORT_A          = 0;
   localparam int PORT_C          = 1;
   localparam int PORT_D          = 2;

   // Gate switch enable bit positions
   localparam int GATE1_BIT       = 0;
   localparam int GATE2_BIT       = 1;

   // Request flag positions
   localparam int REQ_PORT        = 0;
   localparam int REQ_EXT         = 2;
   localparam int REQ_KEY         = 5;

   // Request flags that may release idle: 1..5 and 7
   localparam logic [7:0] HALT_REQ_MASK = 8'hBE;
   // Request flags that block deep-stop entry: 0, 2, 5
   localparam logic [7:0] STOP_REQ_MASK = 8'h25;

   localparam logic [2:0] STOPWAKE_RESET = 3'h0;
   localparam logic [1:0] GATESW_RESET   = 2'h0;
   localparam logic       BACKUP_RESET   = 1'b1;

   // Oscillator restart plus debounce confirmation time in deep-stop wake
   localparam int RESTART_CYCLES  = 16;

   typedef enum logic [1:0] {
      HSWC_RUN  = 2'b00,
      HSWC_IDLE = 2'b01,
      HSWC_STOP = 2'b10,
      HSWC_WAKE = 2'b11
   } hswc_mode_type;

   typedef struct packed {
      logic [PORT_WIDTH-1:0] a;
      logic [PORT_WIDTH-1:0] c;
      logic [PORT_WIDTH-1:0] d;
   } hswc_ports_type;

   typedef struct packed {
      logic idle_op;
      logic stop_op;
      logic return_op;
      logic irq_accept;
      logic set_stopwake_op;
      logic set_gate_switch_op;
      logic clear_request_op;
      logic backup_set_op;
      logic backup_clear_op;
   } hswc_ops_type;

endpackage

// ---- hw/hswc_control.sv ----
`timescale 1ns/1ns
module hswc_control
   import hswc_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire hswc_ops_type             ops,
   input  wire logic [PORT_COUNT-1:0]    op_data,
   input  wire logic [PORT_COUNT-1:0]    switch_en_ports,
   input  wire logic                     debounce_sel,
   input  wire logic [PORT_COUNT-1:0]    port_confirmed,
   input  wire hswc_ports_type           port_inputs,
   input  wire logic                     ext_pin,
   input  wire logic [KEY_WIDTH-1:0]     key_scan_inputs,
   input  wire logic [REQ_WIDTH-1:0]     irq_enable,
   input  wire logic [REQ_WIDTH-1:0]     halt_wake_en,
   input  wire logic [REQ_WIDTH-1:0]     request_set,
   input  wire logic                     gate1_end,
   input  wire logic                     gate2_end,
   input  wire logic [LCD_SEG_WIDTH-1:0] lcd_seg_in,
   input  wire logic [LCD_COM_WIDTH-1:0] lcd_com_in,
   output logic                          cpu_run,
   output logic                          periph_run,
   output logic                          mode_stop,
   output logic                          backup_mode_flag,
   output logic [PORT_COUNT-1:0]         stop_wake_port_enables,
   output logic [PORT_COUNT-1:0]         port_start_cond,
   output logic                          gate1_end_flag,
   output logic                          gate2_end_flag,
   output logic [REQ_WIDTH-1:0]          wake_request_flags,
   output logic [LCD_SEG_WIDTH-1:0]      lcd_segment_outputs,
   output logic [LCD_COM_WIDTH-1:0]      lcd_common_outputs
);

   hswc_mode_type mode;
   hswc_mode_type next_mode;
   hswc_mode_type return_mode;
   logic [1:0]    gate_end_switch_enables;
   logic [7:0]    restart_cnt;

   logic [PORT_COUNT-1:0] port_sync1;
   logic [PORT_COUNT-1:0] port_sync2;
   logic [PORT_COUNT-1:0] port_prev;
   logic                  ext_sync1;
   logic                  ext_sync2;
   logic                  ext_prev;
   logic                  key_sync1;
   logic                  key_sync2;

   function automatic logic any_high(input logic [PORT_WIDTH-1:0] v);
      any_high = |v;
   endfunction

   // Raw OR per port; used both for clockless stop detection and sync
   wire [PORT_COUNT-1:0] port_or_raw = {any_high(port_inputs.d), any_high(port_inputs.c),
                                        any_high(port_inputs.a)};
   wire key_or_raw = |key_scan_inputs;

   wire [PORT_COUNT-1:0] port_rise = port_sync2 & ~port_prev;
   wire                  port_or_chg = (|port_sync2) != (|port_prev);
   wire                  ext_chg = ext_sync2 != ext_prev;

   // Start condition set per port depending on detection method
   wire [PORT_COUNT-1:0] lvl_set = port_rise & switch_en_ports;
   wire [PORT_COUNT-1:0] dbc_set = port_confirmed & switch_en_ports;
   // A synchronised OR change is ignored in stop and wake so a debounced stop wake still waits for confirmation
   wire                  dbc_live = (mode == HSWC_RUN) || (mode == HSWC_IDLE);
   wire [PORT_COUNT-1:0] dbc_chg = (port_or_chg && dbc_live) ? switch_en_ports & (port_sync2 ^ port_prev)
                                                            : '0;
   wire [PORT_COUNT-1:0] start_set = debounce_sel ? dbc_set | dbc_chg : lvl_set;

   wire gate1_set = gate1_end & gate_end_switch_enables[GATE1_BIT];
   wire gate2_set = gate2_end & gate_end_switch_enables[GATE2_BIT];

   // Port and key stop wake candidates read raw pins and need no clock; the ext candidate uses synchronised edges
   wire [PORT_COUNT-1:0] stop_port_ok = debounce_sel ? switch_en_ports & stop_wake_port_enables
                                                     : switch_en_ports;
   wire stop_wake_port = irq_enable[REQ_PORT] & |(port_or_raw & stop_port_ok);
   wire stop_wake_ext  = irq_enable[REQ_EXT] & ext_chg;
   wire stop_wake_key  = irq_enable[REQ_KEY] & key_or_raw;
   wire stop_wake      = stop_wake_port | stop_wake_ext | stop_wake_key;

   wire [REQ_WIDTH-1:0] req_set_now = request_set |
                                      {2'b00, stop_wake_key & (mode == HSWC_STOP), 2'b00,
                                       stop_wake_ext & (mode == HSWC_STOP), 1'b0,
                                       |start_set};
   wire [REQ_WIDTH-1:0] req_next_raw = wake_request_flags | req_set_now;
   wire halt_req_pending = |(wake_request_flags & HALT_REQ_MASK & halt_wake_en);
   wire wake_pending = |port_start_cond | gate1_end_flag | gate2_end_flag | halt_req_pending;
   wire lvl_block = ~debounce_sel & |(port_sync2 & switch_en_ports);
   wire idle_ok = ~wake_pending & ~lvl_block;
   wire stop_ok = ~|(wake_request_flags & STOP_REQ_MASK) & ~|(port_sync2 & switch_en_ports);
   wire idle_wake = wake_pending | (|start_set) | gate1_set | gate2_set | ops.irq_accept;
   wire restart_done = restart_cnt == 8'(RESTART_CYCLES);
   wire confirmed = |port_start_cond | (|start_set);

   always_comb begin
      next_mode = mode;
      case (mode)
         HSWC_RUN: begin
            if (ops.return_op && return_mode != HSWC_RUN) begin
               next_mode = return_mode;
            end else if (ops.idle_op && idle_ok) begin
               next_mode = HSWC_IDLE;
            end else if (ops.stop_op && stop_ok) begin
               next_mode = HSWC_STOP;
            end
         end
         HSWC_IDLE: begin
            if (idle_wake) begin
               next_mode = HSWC_RUN;
            end
         end
         HSWC_STOP: begin
            if (stop_wake) begin
               next_mode = HSWC_WAKE;
            end
         end
         HSWC_WAKE: begin
            if (ops.irq_accept || confirmed || wake_pending) begin
               next_mode = HSWC_RUN;
            end else if (restart_done && !(|port_sync2) && !key_sync2) begin
               next_mode = HSWC_STOP;
            end
         end
         default: next_mode = HSWC_RUN;
      endcase
   end

   // Synchronisers; first stage feeds only the second
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         port_sync1 <= '0;
         port_sync2 <= '0;
         port_prev  <= '0;
         ext_sync1  <= 1'b0;
         ext_sync2  <= 1'b0;
         ext_prev   <= 1'b0;
         key_sync1  <= 1'b0;
         key_sync2  <= 1'b0;
      end else begin
         port_sync1 <= port_or_raw;
         port_sync2 <= port_sync1;
         port_prev  <= port_sync2;
         ext_sync1  <= ext_pin;
         ext_sync2  <= ext_sync1;
         ext_prev   <= ext_sync2;
         key_sync1  <= key_or_raw;
         key_sync2  <= key_sync1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode        <= HSWC_RUN;
         return_mode <= HSWC_RUN;
         restart_cnt <= '0;
      end else begin
         mode <= next_mode;
         if (mode == HSWC_WAKE && !restart_done) begin
            restart_cnt <= restart_cnt + 8'd1;
         end else if (mode != HSWC_WAKE) begin
            restart_cnt <= '0;
         end
         // Remember where an interrupt service routine must return
         if (ops.irq_accept && (mode == HSWC_IDLE || mode == HSWC_WAKE)) begin
            return_mode <= (mode == HSWC_WAKE) ? HSWC_STOP : HSWC_IDLE;
         end else if (ops.return_op || (mode == HSWC_RUN && !ops.irq_accept && return_mode == HSWC_RUN)) begin
            return_mode <= HSWC_RUN;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stop_wake_port_enables  <= STOPWAKE_RESET;
         gate_end_switch_enables <= GATESW_RESET;
         backup_mode_flag        <= BACKUP_RESET;
      end else begin
         if (ops.set_stopwake_op) begin
            stop_wake_port_enables <= op_data;
         end
         if (ops.set_gate_switch_op) begin
            gate_end_switch_enables <= op_data[1:0];
         end
         if (next_mode == HSWC_STOP) begin
            backup_mode_flag <= 1'b1;
         end else if (ops.backup_set_op) begin
            backup_mode_flag <= 1'b1;
         end else if (ops.backup_clear_op) begin
            backup_mode_flag <= 1'b0;
         end
      end
   end

   // Flags: a set in the same cycle as a clear op wins; an accepted interrupt in wake clears request flags outright
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         port_start_cond    <= '0;
         gate1_end_flag     <= 1'b0;
         gate2_end_flag     <= 1'b0;
         wake_request_flags <= '0;
      end else begin
         port_start_cond <= (ops.clear_request_op ? '0 : port_start_cond) | start_set;
         gate1_end_flag  <= (ops.clear_request_op ? 1'b0 : gate1_end_flag) | gate1_set;
         gate2_end_flag  <= (ops.clear_request_op ? 1'b0 : gate2_end_flag) | gate2_set;
         if (ops.irq_accept && mode == HSWC_WAKE) begin
            wake_request_flags <= '0;
         end else if (ops.clear_request_op) begin
            wake_request_flags <= (wake_request_flags & ~{5'b0, op_data}) | req_set_now;
         end else begin
            wake_request_flags <= req_next_raw;
         end
      end
   end

   // Outputs registered; LCD grounded throughout deep-stop
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cpu_run             <= 1'b1;
         periph_run          <= 1'b1;
         mode_stop           <= 1'b0;
         lcd_segment_outputs <= '0;
         lcd_common_outputs  <= '0;
      end else begin
         cpu_run             <= next_mode == HSWC_RUN;
         periph_run          <= next_mode != HSWC_STOP;
         mode_stop           <= next_mode == HSWC_STOP;
         lcd_segment_outputs <= (next_mode == HSWC_STOP) ? '0 : lcd_seg_in;
         lcd_common_outputs  <= (next_mode == HSWC_STOP) ? '0 : lcd_com_in;
      end
   end

endmodule

// ---- bench/hswc_control_assertions.sv ----
`timescale 1ns/1ns
module hswc_control_assertions
   import hswc_pkg::*;
(
   input wire logic                     mclk,
   input wire logic                     rst,
   input wire hswc_ops_type             ops,
   input wire logic [PORT_COUNT-1:0]    op_data,
   input wire logic [REQ_WIDTH-1:0]     halt_wake_en,
   input wire logic                     gate1_end,
   input wire logic                     gate2_end,
   input wire logic                     cpu_run,
   input wire logic                     periph_run,
   input wire logic                     mode_stop,
   input wire logic                     backup_mode_flag,
   input wire logic [PORT_COUNT-1:0]    stop_wake_port_enables,
   input wire logic                     gate1_end_flag,
   input wire logic                     gate2_end_flag,
   input wire logic [REQ_WIDTH-1:0]     wake_request_flags,
   input wire logic [LCD_SEG_WIDTH-1:0] lcd_segment_outputs,
   input wire logic [LCD_COM_WIDTH-1:0] lcd_common_outputs
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   lcd_ground_a: assert property (mode_stop |-> lcd_segment_outputs == '0 && lcd_common_outputs == '0)
      else $error("display outputs active in deep stop");
   stop_halt_a: assert property (mode_stop |-> !periph_run)
      else $error("peripherals running in deep stop");
   stop_backup_a: assert property ($rose(mode_stop) |-> backup_mode_flag)
      else $error("backup flag clear on deep stop entry");
   // Single-op guard: combined ops resolve return over idle over stop, so they are left out here
   idle_refuse_a: assert property (ops.idle_op && $countones(ops) == 1 && cpu_run && (gate1_end_flag ||
      gate2_end_flag || |(wake_request_flags & halt_wake_en & HALT_REQ_MASK)) |=> cpu_run)
      else $error("idle entered with wake factor pending");
   stop_refuse_a: assert property (ops.stop_op && $countones(ops) == 1 && cpu_run && !mode_stop
      && |(wake_request_flags & STOP_REQ_MASK) |=> !mode_stop)
      else $error("deep stop entered with request pending");
   gate1_wake_a: assert property ($rose(gate1_end_flag) |-> $past(gate1_end) && cpu_run)
      else $error("first gate flag without gate end or wake");
   gate2_wake_a: assert property ($rose(gate2_end_flag) |-> $past(gate2_end) && cpu_run)
      else $error("second gate flag without gate end or wake");
   stopwake_write_a: assert property (ops.set_stopwake_op |=> stop_wake_port_enables == $past(op_data))
      else $error("stop wake enables not written");
   irq_wake_a: assert property (ops.irq_accept && $countones(ops) == 1 && !cpu_run && !mode_stop |=> cpu_run)
      else $error("accepted interrupt did not resume execution");
endmodule

bind hswc_control hswc_control_assertions i_hswc_control_assertions (.mclk, .rst, .ops, .op_data, .halt_wake_en,
   .gate1_end, .gate2_end, .cpu_run, .periph_run, .mode_stop, .backup_mode_flag, .stop_wake_port_enables,
   .gate1_end_flag, .gate2_end_flag, .wake_request_flags, .lcd_segment_outputs, .lcd_common_outputs);

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench
   import hswc_pkg::*;
;
   localparam hswc_ops_type op_idle = 9'h100;
   localparam hswc_ops_type op_stop = 9'h080;
   localparam hswc_ops_type op_ret  = 9'h040;
   localparam hswc_ops_type op_irq  = 9'h020;
   localparam hswc_ops_type op_swk  = 9'h010;
   localparam hswc_ops_type op_gate = 9'h008;
   localparam hswc_ops_type op_clr  = 9'h004;
   localparam hswc_ops_type op_bclr = 9'h001;
   logic mclk = 0, rst = 1, debounce_sel = 1, ext_pin = 0, gate1_end = 0, gate2_end = 0;
   hswc_ops_type   ops = '0;
   hswc_ports_type port_inputs = '0;
   logic [2:0]  op_data = '0, switch_en_ports = '0, port_confirmed = '0, stop_wake_port_enables, port_start_cond;
   logic [7:0]  irq_enable = '0, halt_wake_en = '0, request_set = '0, wake_request_flags;
   logic [3:0]  key_scan_inputs = '0, lcd_com_in = 4'h9, lcd_common_outputs;
   logic [31:0] lcd_seg_in = 32'hA5A5_5A5A, lcd_segment_outputs;
   logic cpu_run, periph_run, mode_stop, backup_mode_flag, gate1_end_flag, gate2_end_flag;
   int   err_count = 0, compares = 0;

   hswc_control i_hswc_control (.mclk, .rst, .ops, .op_data, .switch_en_ports, .debounce_sel, .port_confirmed,
      .port_inputs, .ext_pin, .key_scan_inputs, .irq_enable, .halt_wake_en, .request_set, .gate1_end, .gate2_end,
      .lcd_seg_in, .lcd_com_in, .cpu_run, .periph_run, .mode_stop, .backup_mode_flag, .stop_wake_port_enables,
      .port_start_cond, .gate1_end_flag, .gate2_end_flag, .wake_request_flags, .lcd_segment_outputs,
      .lcd_common_outputs);

   always #10 mclk = ~mclk;

   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task close_out;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task do_reset;
      rst = 1;
      port_inputs = '0;
      switch_en_ports = '0;
      halt_wake_en = '0;
      repeat (20) @(negedge mclk);
      rst = 0;
      @(negedge mclk);
   endtask
   // Ops are single-cycle pulses; the idle edge after lets outputs settle
   task op(input hswc_ops_type o, input logic [2:0] d);
      ops = o;
      op_data = d;
      @(negedge mclk);
      ops = '0;
      @(negedge mclk);
   endtask
   task pulse(input logic [7:0] r, input bit g1, input bit g2);
      request_set = r;
      gate1_end = g1;
      gate2_end = g2;
      @(negedge mclk);
      {request_set, gate1_end, gate2_end} = '0;
      @(negedge mclk);
   endtask
   // Wake passes synchronisers and a restart count, so poll under a bound
   task automatic wait_on(input bit sel, input logic v);
      int i;
      for (i = 0; i < 60 && (sel ? mode_stop : cpu_run) !== v; i++) @(negedge mclk);
      chk(sel ? "mode_stop" : "cpu_run", v, sel ? mode_stop : cpu_run);
      if (i == 60) close_out;
   endtask

   task t_reset_values;
      chk("cpu_run", 1, cpu_run);
      chk("mode_stop", 0, mode_stop);
      chk("backup_mode_flag", 1, backup_mode_flag);
      chk("stop_wake_port_enables", 0, stop_wake_port_enables);
      chk("lcd_segment_outputs", 32'hA5A5_5A5A, lcd_segment_outputs);
      chk("lcd_common_outputs", 4'h9, lcd_common_outputs);
   endtask
   task t_stopwake;
      op(op_swk, 3'h5);
      chk("stop_wake_port_enables", 5, stop_wake_port_enables);
      op(op_swk, 3'h2);
      chk("stop_wake_port_enables", 2, stop_wake_port_enables);
   endtask
   task t_gate;
      op(op_gate, 3'h1);
      op(op_idle, 0);
      chk("cpu_run", 0, cpu_run);
      chk("periph_run", 1, periph_run);
      pulse(0, 0, 1);
      chk("gate2_end_flag", 0, gate2_end_flag);
      pulse(0, 1, 0);
      chk("gate1_end_flag", 1, gate1_end_flag);
      chk("cpu_run", 1, cpu_run);
      op(op_idle, 0);
      chk("cpu_run", 1, cpu_run);
      op(op_clr, 0);
      op(op_gate, 3'h2);
      op(op_idle, 0);
      pulse(0, 0, 1);
      chk("gate2_end_flag", 1, gate2_end_flag);
      chk("cpu_run", 1, cpu_run);
   endtask
   task t_halt_req;
      halt_wake_en = 8'h02;
      op(op_idle, 0);
      pulse(8'h02, 0, 0);
      chk("cpu_run", 1, cpu_run);
      op(op_idle, 0);
      chk("cpu_run", 1, cpu_run);
      op(op_clr, 3'h2);
      op(op_idle, 0);
      chk("cpu_run", 0, cpu_run);
      op(op_irq, 0);
      chk("cpu_run", 1, cpu_run);
      op(op_ret, 0);
      chk("cpu_run", 0, cpu_run);
   endtask
   task t_level;
      debounce_sel = 0;
      switch_en_ports = 3'h1;
      port_inputs.a = 4'h4;
      repeat (4) @(negedge mclk);
      op(op_idle, 0);
      chk("cpu_run", 1, cpu_run);
      port_inputs.a = 4'h0;
      repeat (4) @(negedge mclk);
      op(op_clr, 0);
      op(op_idle, 0);
      chk("cpu_run", 0, cpu_run);
      port_inputs.c = 4'h1;
      repeat (6) @(negedge mclk);
      chk("cpu_run", 0, cpu_run);
      port_inputs.a = 4'h8;
      wait_on(0, 1);
      chk("port_start_cond_a", 1, port_start_cond[PORT_A]);
   endtask
   task t_stop;
      irq_enable = 8'h04;
      pulse(8'h04, 0, 0);
      op(op_stop, 0);
      chk("mode_stop", 0, mode_stop);
      op(op_clr, 3'h4);
      op(op_bclr, 0);
      chk("backup_mode_flag", 0, backup_mode_flag);
      op(op_stop, 0);
      chk("mode_stop", 1, mode_stop);
      chk("backup_mode_flag", 1, backup_mode_flag);
      chk("lcd_segment_outputs", 0, lcd_segment_outputs);
      chk("lcd_common_outputs", 0, lcd_common_outputs);
      ext_pin = 1;
      wait_on(1, 0);
      chk("ext_request_flag", 1, wake_request_flags[REQ_EXT]);
      op(op_irq, 0);
      chk("wake_request_flags", 0, wake_request_flags);
      chk("cpu_run", 1, cpu_run);
      chk("lcd_segment_outputs", 32'hA5A5_5A5A, lcd_segment_outputs);
      op(op_ret, 0);
      wait_on(1, 1);
   endtask
   task t_debounce;
      debounce_sel = 1;
      switch_en_ports = 3'h3;
      irq_enable = 8'h01;
      op(op_swk, 3'h2);
      op(op_stop, 0);
      chk("mode_stop", 1, mode_stop);
      port_inputs.a = 4'h1;
      repeat (6) @(negedge mclk);
      chk("mode_stop", 1, mode_stop);
      port_inputs.a = 4'h0;
      repeat (4) @(negedge mclk);
      port_inputs.c = 4'h2;
      wait_on(1, 0);
      port_confirmed = 3'h2;
      @(negedge mclk);
      port_confirmed = 3'h0;
      wait_on(0, 1);
      chk("port_start_cond_c", 1, port_start_cond[PORT_C]);
      port_inputs.c = 4'h0;
      repeat (4) @(negedge mclk);
      op(op_clr, 3'h1);
      op(op_stop, 0);
      chk("mode_stop", 1, mode_stop);
      port_inputs.c = 4'h2;
      wait_on(1, 0);
      port_inputs.c = 4'h0;
      wait_on(1, 1);
      irq_enable = 8'h21;
      key_scan_inputs = 4'h4;
      wait_on(1, 0);
      chk("key_request_flag", 1, wake_request_flags[REQ_KEY]);
   endtask

   initial begin
      do_reset;
      t_reset_values;
      t_stopwake;
      t_gate;
      do_reset;
      t_halt_req;
      do_reset;
      t_level;
      do_reset;
      t_stop;
      do_reset;
      t_debounce;
      close_out;
   end
endmodule
